// ===== core/pbf_defs.vh
// Constants of the PCM packet body formatter
`ifndef PBF_DEFS_VH
`define PBF_DEFS_VH

// Register offsets (word addresses on the plain register port)
`define PBF_REG_CTRL        4'h0
`define PBF_REG_CSDW        4'h1
`define PBF_REG_FLAGS       4'h2
`define PBF_REG_ABS_LO      4'h3
`define PBF_REG_ABS_HI      4'h4
`define PBF_REG_STATUS      4'h5
`define PBF_REG_COUNT       4'h6

// Control register fields
`define PBF_CTRL_EN         0
`define PBF_CTRL_START      1
`define PBF_CTRL_ABS_LATCH  2

// Channel-specific data word fields
`define PBF_CSDW_THRU       18
`define PBF_CSDW_ALIGN32    21

// Packet flag fields
`define PBF_FLAG_ABS_EN     6
`define PBF_FLAG_FMT_LO     2
`define PBF_FLAG_FMT_HI     3

// Frame data header fields
`define PBF_HDR_MINOR_HI    15
`define PBF_HDR_MINOR_LO    14
`define PBF_HDR_MAJOR_HI    13
`define PBF_HDR_MAJOR_LO    12

// Reset values
`define PBF_CSDW_RST        32'h00000000
`define PBF_FLAGS_RST       8'h00

// Header lengths in 16-bit words
`define PBF_HDR_WORDS16     3'h5
`define PBF_HDR_WORDS32     3'h6

`endif

// ===== core/pbf_formatter.v
// PCM packet body formatter: channel word, throughput data, per-frame header
//
// Contract
// - Throughput packs bits without frame sync
// - Channel word low half then high half
// - 32-bit throughput: bits 17-32 before 1-16
// - Stream enters words from right, MSB first
// - Each minor frame gets time tag and header
// - Data header width follows alignment mode
// - Header sits right before sync pattern
// - Header is 10 or 12 contiguous bytes
// - 32-bit data header upper half zero
// - Default tag is 48-bit counter, zero-extended
// - Flag bit 6 selects absolute time tag
// - No time tag in throughput mode
// - Bits 15-14 carry minor frame state
// - Bits 13-12 carry major frame state
// - Bits 11-0 reserved
//
// The placing of the registers and strobed register access were chosen for this implementation.
`include "pbf_defs.vh"

module pbf_formatter #(
    parameter RTC_W = 48
) (
    input  wire             sys_clk,       // 250 MHz clock
    input  wire             sys_rst,       // Synchronous reset, active high
    input  wire [3:0]       reg_addr,      // Register word address
    input  wire [31:0]      reg_wdata,     // Register write data
    input  wire             reg_wr,        // Register write strobe
    input  wire             reg_rd,        // Register read strobe
    output reg  [31:0]      reg_rdata_q,   // Read data, cycle after strobe
    input  wire             pcm_bit_vld,   // Serial PCM bit valid
    input  wire             pcm_bit,       // Serial PCM bit
    input  wire             frame_start,   // First bit of minor frame sync
    input  wire [1:0]       minor_state,   // Minor frame lock state
    input  wire [1:0]       major_state,   // Major frame lock state
    input  wire [RTC_W-1:0] rtc_value,     // Relative time counter
    output reg  [15:0]      out_data_q,    // Body half-word
    output reg              out_vld_q,     // Body half-word valid
    output reg              out_hdr_q      // Half-word is part of frame header
);
    // ****************************************************************
    // Registers
    // ****************************************************************
    localparam S_IDLE = 2'h0;
    localparam S_CSDW = 2'h1;
    localparam S_BODY = 2'h2;

    reg         enable_q;
    reg [31:0]  csdw_q;
    reg [7:0]   flags_q;
    reg [63:0]  abs_time_q;
    reg [31:0]  word_cnt_q;
    reg [1:0]   state_q;
    reg         csdw_hi_q;
    reg         start_q;

    wire thru    = csdw_q[`PBF_CSDW_THRU];
    wire align32 = csdw_q[`PBF_CSDW_ALIGN32];
    wire abs_en  = flags_q[`PBF_FLAG_ABS_EN];

    always @(posedge sys_clk) begin
        start_q <= 1'b0;
        if (sys_rst) begin
            enable_q   <= 1'b0;
            csdw_q     <= `PBF_CSDW_RST;
            flags_q    <= `PBF_FLAGS_RST;
            abs_time_q <= 64'h0000000000000000;
        end else if (reg_wr) begin
            if (reg_addr == `PBF_REG_CTRL) begin
                enable_q <= reg_wdata[`PBF_CTRL_EN];
                start_q  <= reg_wdata[`PBF_CTRL_START];
            end else if (reg_addr == `PBF_REG_CSDW) begin
                csdw_q <= reg_wdata;
            end else if (reg_addr == `PBF_REG_FLAGS) begin
                flags_q <= reg_wdata[7:0];
            end else if (reg_addr == `PBF_REG_ABS_LO) begin
                abs_time_q[31:0] <= reg_wdata;
            end else if (reg_addr == `PBF_REG_ABS_HI) begin
                abs_time_q[63:32] <= reg_wdata;
            end
        end
    end

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_rdata_q <= 32'h00000000;
        end else if (reg_rd) begin
            if (reg_addr == `PBF_REG_CTRL) begin
                reg_rdata_q <= {31'h00000000, enable_q};
            end else if (reg_addr == `PBF_REG_CSDW) begin
                reg_rdata_q <= csdw_q;
            end else if (reg_addr == `PBF_REG_FLAGS) begin
                reg_rdata_q <= {24'h000000, flags_q};
            end else if (reg_addr == `PBF_REG_ABS_LO) begin
                reg_rdata_q <= abs_time_q[31:0];
            end else if (reg_addr == `PBF_REG_ABS_HI) begin
                reg_rdata_q <= abs_time_q[63:32];
            end else if (reg_addr == `PBF_REG_STATUS) begin
                reg_rdata_q <= {26'h0000000, major_state, minor_state, state_q};
            end else if (reg_addr == `PBF_REG_COUNT) begin
                reg_rdata_q <= word_cnt_q;
            end else begin
                reg_rdata_q <= 32'h00000000;
            end
        end else begin
            reg_rdata_q <= 32'h00000000;
        end
    end

    // ****************************************************************
    // Per-frame header capture
    // ****************************************************************
    // Time and lock state are taken at the frame's first bit; that bit goes
    // straight into the packer, so no stream bit is lost during the header.
    reg  [63:0] tag_q;
    reg  [15:0] lock_q;
    reg  [2:0]  hdr_idx_q;
    reg         hdr_busy_q;
    wire [2:0]  hdr_len = align32 ? `PBF_HDR_WORDS32 : `PBF_HDR_WORDS16;
    wire        frame_go = pcm_bit_vld && frame_start && !thru &&
                           state_q == S_BODY;

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            tag_q  <= 64'h0000000000000000;
            lock_q <= 16'h0000;
        end else if (frame_go) begin
            if (abs_en) begin
                tag_q <= abs_time_q;
            end else begin
                tag_q <= {{(64 - RTC_W){1'b0}}, rtc_value};
            end
            lock_q <= {minor_state, major_state, 12'h000};
        end
    end

    // ****************************************************************
    // Data path
    // ****************************************************************
    wire        pk_vld = pcm_bit_vld && state_q == S_BODY;
    wire        pk_val = pcm_bit;
    wire [31:0] pk_word;
    wire        pk_word_vld;
    reg  [15:0] pend_q;
    reg         pend_vld_q;

    pbf_word_packer #(
        .W(32)
    ) u_packer (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .clear      (start_q),
        .bit_vld    (pk_vld),
        .bit_val    (pk_val),
        .wide       (align32),
        .word_q     (pk_word),
        .word_vld_q (pk_word_vld)
    );

    reg [15:0] hdr_word;
    always @* begin
        hdr_word = 16'h0000;
        case (hdr_idx_q)
            3'h0: hdr_word = tag_q[15:0];
            3'h1: hdr_word = tag_q[31:16];
            3'h2: hdr_word = tag_q[47:32];
            3'h3: hdr_word = tag_q[63:48];
            3'h4: hdr_word = lock_q;
            default: hdr_word = 16'h0000;
        endcase
    end

    // Header and data collide only if a word completes on the frame_go cycle or in the header burst,
    // which drops it; a frame starting a word needs 15 more bits (31 with align32), so the header leads that word.
    always @(posedge sys_clk) begin
        out_vld_q <= 1'b0;
        out_hdr_q <= 1'b0;
        if (sys_rst) begin
            state_q    <= S_IDLE;
            csdw_hi_q  <= 1'b0;
            hdr_idx_q  <= 3'h0;
            hdr_busy_q <= 1'b0;
            pend_q     <= 16'h0000;
            pend_vld_q <= 1'b0;
            out_data_q <= 16'h0000;
            word_cnt_q <= 32'h00000000;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (start_q && enable_q) begin
                        state_q   <= S_CSDW;
                        csdw_hi_q <= 1'b0;
                    end
                end
                S_CSDW: begin
                    out_vld_q  <= 1'b1;
                    out_data_q <= csdw_hi_q ? csdw_q[31:16] : csdw_q[15:0];
                    csdw_hi_q  <= 1'b1;
                    if (csdw_hi_q) begin
                        state_q <= S_BODY;
                    end
                end
                default: begin
                    if (!enable_q) begin
                        state_q <= S_IDLE;
                    end
                    if (frame_go) begin
                        hdr_busy_q <= 1'b1;
                        hdr_idx_q  <= 3'h0;
                    end else if (hdr_busy_q) begin
                        out_vld_q  <= 1'b1;
                        out_hdr_q  <= 1'b1;
                        out_data_q <= hdr_word;
                        hdr_idx_q  <= hdr_idx_q + 3'h1;
                        if (hdr_idx_q == hdr_len - 3'h1) begin
                            hdr_busy_q <= 1'b0;
                        end
                    end else if (pk_word_vld) begin
                        out_vld_q  <= 1'b1;
                        word_cnt_q <= word_cnt_q + 32'h00000001;
                        if (align32) begin
                            out_data_q <= pk_word[15:0];
                            pend_q     <= pk_word[31:16];
                            pend_vld_q <= 1'b1;
                        end else begin
                            out_data_q <= pk_word[15:0];
                        end
                    end else if (pend_vld_q) begin
                        out_vld_q  <= 1'b1;
                        out_data_q <= pend_q;
                        pend_vld_q <= 1'b0;
                    end
                end
            endcase
        end
    end
endmodule

// ===== core/pbf_word_packer.v
// Serial-to-16/32-bit word packer for the packet body formatter
module pbf_word_packer #(
    parameter W = 32
) (
    input  wire         sys_clk,    // Clock
    input  wire         sys_rst,    // Synchronous reset, active high
    input  wire         clear,      // Drop partial word
    input  wire         bit_vld,    // Serial bit valid
    input  wire         bit_val,    // Serial bit value
    input  wire         wide,       // 1: 32-bit words, 0: 16-bit words
    output reg  [W-1:0] word_q,     // Completed word
    output reg          word_vld_q  // Completed word pulse
);
    reg  [W-1:0] shift_q;
    reg  [5:0]   cnt_q;
    wire [W-1:0] shift_d = {shift_q[W-2:0], bit_val};
    wire [5:0]   last    = wide ? 6'h1f : 6'h0f;

    // Bits enter at the right, so the first bit ends up most significant
    always @(posedge sys_clk) begin
        word_vld_q <= 1'b0;
        if (sys_rst || clear) begin
            shift_q <= {W{1'b0}};
            cnt_q   <= 6'h00;
            word_q  <= {W{1'b0}};
        end else if (bit_vld) begin
            shift_q <= shift_d;
            if (cnt_q == last) begin
                cnt_q      <= 6'h00;
                word_q     <= shift_d;
                word_vld_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 6'h01;
            end
        end
    end
endmodule

// ===== tb/pbf_formatter_properties.sv
// Assertion checker for the PCM packet body formatter
`include "pbf_defs.vh"
module pbf_formatter_checker #(
    parameter RTC_W = 48
) (
    input wire             sys_clk,     // Clock
    input wire             sys_rst,     // Reset
    input wire [3:0]       reg_addr,    // Address
    input wire [31:0]      reg_wdata,   // Write data
    input wire             reg_wr,      // Write strobe
    input wire             pcm_bit_vld, // Bit valid
    input wire             frame_start, // Frame start
    input wire [1:0]       minor_state, // Minor lock
    input wire [1:0]       major_state, // Major lock
    input wire [RTC_W-1:0] rtc_value,   // Time counter
    input wire [15:0]      out_data_q,  // Body word
    input wire             out_vld_q,   // Body valid
    input wire             out_hdr_q    // Header word
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic [31:0]      csdw_q;
    logic             abs_q;
    logic [RTC_W-1:0] rtc_q;
    logic [3:0]       lock_q;
    wire              fs = frame_start && pcm_bit_vld;
    // Shadow the mode registers so the header shape can be predicted
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            csdw_q <= 32'h0;
            abs_q <= 1'b0;
        end else if (reg_wr && reg_addr == `PBF_REG_CSDW) begin
            csdw_q <= reg_wdata;
        end else if (reg_wr && reg_addr == `PBF_REG_FLAGS) begin
            abs_q <= reg_wdata[`PBF_FLAG_ABS_EN];
        end
        if (fs) begin
            rtc_q <= rtc_value;
            lock_q <= {minor_state, major_state};
        end
    end
    // ****************
    // Sequences and properties
    // ****************
    sequence s_csdw;
        out_vld_q && out_data_q == csdw_q[15:0] ##1 out_vld_q && out_data_q == csdw_q[31:16];
    endsequence
    sequence s_hdr16;
        out_hdr_q [*5] ##1 !out_hdr_q;
    endsequence
    sequence s_hdr32;
        out_hdr_q [*6] ##1 !out_hdr_q;
    endsequence
    sequence s_rtc;
        out_data_q == rtc_q[15:0] ##1 out_data_q == rtc_q[31:16]
            ##1 out_data_q == rtc_q[47:32] ##1 out_data_q == 16'h0000;
    endsequence
    property p_csdw;
        reg_wr && reg_addr == `PBF_REG_CTRL && reg_wdata[1:0] == 2'b11 |-> ##[1:6] s_csdw;
    endproperty
    property p_cause;
        $rose(out_hdr_q) |-> $past(fs, 2);
    endproperty
    property p_hdr_vld;
        out_hdr_q |-> out_vld_q;
    endproperty
    property p_len16;
        !csdw_q[`PBF_CSDW_ALIGN32] && $rose(out_hdr_q) |-> s_hdr16;
    endproperty
    property p_len32;
        csdw_q[`PBF_CSDW_ALIGN32] && $rose(out_hdr_q) |-> s_hdr32;
    endproperty
    property p_rtc;
        !abs_q && $rose(out_hdr_q) |-> s_rtc;
    endproperty
    property p_lock;
        $rose(out_hdr_q) |-> ##4 out_data_q == {lock_q, 12'h000};
    endproperty
    property p_zero32;
        csdw_q[`PBF_CSDW_ALIGN32] && $rose(out_hdr_q) |-> ##5 out_data_q == 16'h0000;
    endproperty
    property p_no_thru_hdr;
        csdw_q[`PBF_CSDW_THRU] |-> !out_hdr_q;
    endproperty
    a_csdw: assert property (p_csdw) else $error("channel word not sent low half first");
    a_cause: assert property (p_cause) else $error("header without frame start");
    a_hdr_vld: assert property (p_hdr_vld) else $error("header flag without valid");
    a_len16: assert property (p_len16) else $error("16-bit header not five words");
    a_len32: assert property (p_len32) else $error("32-bit header not six words");
    a_rtc: assert property (p_rtc) else $error("time tag differs from counter");
    a_lock: assert property (p_lock) else $error("lock word wrong");
    a_zero32: assert property (p_zero32) else $error("upper data header not zero");
    a_no_thru_hdr: assert property (p_no_thru_hdr) else $error("header in throughput");
endmodule
bind pbf_formatter pbf_formatter_checker #(.RTC_W(RTC_W)) chk_u (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .pcm_bit_vld(pcm_bit_vld), .frame_start(frame_start), .minor_state(minor_state),
    .major_state(major_state), .rtc_value(rtc_value), .out_data_q(out_data_q),
    .out_vld_q(out_vld_q), .out_hdr_q(out_hdr_q));

// ===== tb/pbf_pcm_src.sv
// Serial PCM source standing in for the frame synchronizer
module pbf_pcm_src (
    input  wire        sys_clk,     // Clock
    input  wire        go,          // Start a burst
    input  wire [63:0] pat,         // Bits, MSB first
    input  wire [6:0]  n_bits,      // Burst length
    input  wire [6:0]  sync_idx,    // Bit flagged as frame start
    output logic       pcm_bit_vld, // Bit valid
    output logic       pcm_bit,     // Bit value
    output logic       frame_start, // Sync flag
    output logic       busy         // Burst running
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] cnt = 7'h0;
    logic [1:0] gap = 2'h0;
    initial begin
        busy = 1'b0;
        pcm_bit_vld = 1'b0;
        pcm_bit = 1'b0;
        frame_start = 1'b0;
    end
    // Three idle cycles per bit leave the header room before the next word
    always @(posedge sys_clk) begin
        pcm_bit_vld <= 1'b0;
        frame_start <= 1'b0;
        pcm_bit <= ~pcm_bit;
        gap <= gap + 2'h1;
        if (go) begin
            busy <= 1'b1;
            cnt <= 7'h0;
            gap <= 2'h0;
        end else if (busy && gap == 2'h3) begin
            pcm_bit_vld <= 1'b1;
            pcm_bit <= pat[7'd63 - cnt];
            frame_start <= (cnt == sync_idx);
            cnt <= cnt + 7'h01;
            busy <= (cnt != n_bits - 7'h01);
        end
    end
endmodule

// ===== tb/test_pcm_packet_body_formatter.sv
// Self-checking bench for the PCM packet body formatter
module test_pcm_packet_body_formatter;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(g, w) begin n_checks++; if ((g) !== (w)) begin bad_count++; \
    $display("Error at %0t: got %h want %h", $time, g, w); end end
    logic        sys_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, go = 0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [1:0]  minor_state = 2'h0, major_state = 2'h0;
    logic [47:0] rtc_value = 48'h0abc_1234_5678;
    logic [63:0] pat = 64'h0;
    logic [6:0]  n_bits = 7'h0, sync_idx = 7'h7f;
    wire         pcm_bit_vld, pcm_bit, frame_start, busy, out_vld_q, out_hdr_q;
    wire  [31:0] reg_rdata_q;
    wire  [15:0] out_data_q;
    int          bad_count = 0, n_checks = 0, cyc = 0;
    logic [16:0] got[$], exp[$];
    pbf_formatter dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .pcm_bit_vld(pcm_bit_vld), .pcm_bit(pcm_bit), .frame_start(frame_start),
        .minor_state(minor_state), .major_state(major_state), .rtc_value(rtc_value),
        .out_data_q(out_data_q), .out_vld_q(out_vld_q), .out_hdr_q(out_hdr_q));
    pbf_pcm_src src_u (.sys_clk(sys_clk), .go(go), .pat(pat), .n_bits(n_bits),
        .sync_idx(sync_idx), .pcm_bit_vld(pcm_bit_vld), .pcm_bit(pcm_bit),
        .frame_start(frame_start), .busy(busy));
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (out_vld_q === 1'b1) got.push_back({out_hdr_q, out_data_q});
        if (cyc == 4000) begin
            bad_count++;
            give_verdict();
        end
    end
    task give_verdict;
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task wr(input [3:0] a, input [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input [3:0] a, input [31:0] w);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 `CHK(reg_rdata_q, w)
    endtask
    // Restart the stream, send one burst, compare every emitted half-word
    task run(input [31:0] csdw, input [7:0] flg, input [63:0] p, input [6:0] n, s);
        wr(4'h0, 32'h0);
        wr(4'h1, csdw);
        wr(4'h2, {24'h0, flg});
        got.delete();
        wr(4'h0, 32'h3);
        repeat (8) @(posedge sys_clk);
        pat <= p;
        n_bits <= n;
        sync_idx <= s;
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        repeat (4 * n + 30) @(posedge sys_clk);
        `CHK(got.size(), exp.size())
        foreach (exp[i]) `CHK(got[i], exp[i])
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        exp = '{17'h0_a5c3, 17'h0_0004, 17'h0_1234, 17'h0_5678};
        run(32'h0004_a5c3, 8'h00, {32'h1234_5678, 32'h0}, 7'd32, 7'd0);
        exp = '{17'h0_0000, 17'h0_0024, 17'h0_5678, 17'h0_1234};
        run(32'h0024_0000, 8'h00, {32'h1234_5678, 32'h0}, 7'd32, 7'd127);
        minor_state <= 2'b11;
        major_state <= 2'b10;
        exp = '{17'h0_0000, 17'h0_0000, 17'h0_beef, 17'h1_5678, 17'h1_1234, 17'h1_0abc,
                17'h1_0000, 17'h1_e000, 17'h0_fe6b};
        run(32'h0, 8'h00, {32'hbeef_fe6b, 32'h0}, 7'd32, 7'd16);
        minor_state <= 2'b10;
        major_state <= 2'b00;
        wr(4'h3, 32'h89ab_cdef);
        wr(4'h4, 32'h0123_4567);
        exp = '{17'h0_0000, 17'h0_0020, 17'h0_f00d, 17'h0_cafe, 17'h1_cdef, 17'h1_89ab,
                17'h1_4567, 17'h1_0123, 17'h1_8000, 17'h1_0000, 17'h0_1dea, 17'h0_0bad};
        run(32'h0020_0000, 8'h4c, 64'hcafe_f00d_0bad_1dea, 7'd64, 7'd32);
        rd(4'h1, 32'h0020_0000);
        rd(4'h2, 32'h0000_004c);
        rd(4'hf, 32'h0);
        give_verdict();
    end
endmodule
